//--- rtl/tvr_low_latch.sv
// one channel's low-byte freeze: live copy or frozen shadow
// assumes capture and release are one-cycle pulses from the read decoder
module tvr_low_latch
    import tvr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // live low byte and read events
    input wire logic [7:0] live_low_in,
    input wire logic capture_in,
    input wire logic release_in,
    // view seen by the host
    output logic locked_out,
    output logic [7:0] low_view_out
);
    logic [7:0] shadow;

    // capture wins: a high read always overrides an older freeze
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            locked_out <= 1'b0;
        end else if (capture_in) begin
            locked_out <= 1'b1;
        end else if (release_in) begin
            locked_out <= 1'b0;
        end
    end

    // shadow keeps the frozen copy so the live byte may keep moving
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            shadow <= RESULT_RESET;
        end else if (capture_in) begin
            shadow <= live_low_in;
        end
    end

    assign low_view_out = locked_out ? shadow : live_low_in;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    AST_FROZEN_STABLE: assert property (
        locked_out && !capture_in |=> $stable(shadow))
        else $error("frozen low byte changed while locked");

    AST_RECAPTURE: assert property (
        capture_in |=> locked_out && low_view_out == $past(live_low_in))
        else $error("high read did not capture current low byte");

    AST_UNLOCKED_LIVE: assert property (
        release_in && !capture_in |=> low_view_out == live_low_in)
        else $error("released low byte does not follow live value");
endmodule : tvr_low_latch

//--- rtl/tvr_readout.sv
// read side of the temperature result registers, three channels
// assumes the bus engine gives the selected command code and a read pulse,
// and that converter results arrive on the same clock
module tvr_readout
    import tvr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // converter results, one valid pulse per channel
    input wire logic [NUM_CHAN-1:0] conv_valid_in,
    input wire logic [7:0] local_high_in,
    input wire logic [LOCAL_FRAC_W-1:0] local_frac_in,
    input wire logic [7:0] remote1_high_in,
    input wire logic [REMOTE_FRAC_W-1:0] remote1_frac_in,
    input wire logic [7:0] remote2_high_in,
    input wire logic [REMOTE_FRAC_W-1:0] remote2_frac_in,
    // digital filter enable, bit 0 remote 1, bit 1 remote 2
    input wire logic [1:0] filter_on_in,
    // register read port from the bus engine
    input wire logic [7:0] cmd_in,
    input wire logic rd_strobe_in,
    output logic [7:0] rd_data_out,
    output logic rd_ack_out,
    output logic rd_hit_out,
    // freeze state per channel
    output logic [NUM_CHAN-1:0] low_locked_out
);
    logic [7:0] conv_high [NUM_CHAN];
    logic [7:0] conv_low [NUM_CHAN];
    logic [7:0] live_high [NUM_CHAN];
    logic [7:0] live_low [NUM_CHAN];
    logic [7:0] low_view [NUM_CHAN];
    logic [NUM_CHAN-1:0] hi_sel;
    logic [NUM_CHAN-1:0] lo_sel;
    logic [7:0] rd_value;
    logic rd_match;
    logic [7:0] last_cmd;

    // format converter words into register bytes
    always_comb begin
        conv_high[CH_LOCAL] = local_high_in;
        conv_high[CH_REMOTE1] = remote1_high_in;
        conv_high[CH_REMOTE2] = remote2_high_in;
        // local: three fraction bits on top, low five zero
        conv_low[CH_LOCAL] = {local_frac_in, {LOCAL_RSVD_W{1'b0}}};
        // remote: top three always, next two only with filter, last three zero
        conv_low[CH_REMOTE1] = {remote1_frac_in[REMOTE_FRAC_W-1:FILT_BITS_W],
            remote1_frac_in[FILT_BITS_W-1:0] & {FILT_BITS_W{filter_on_in[0]}},
            {REMOTE_RSVD_W{1'b0}}};
        conv_low[CH_REMOTE2] = {remote2_frac_in[REMOTE_FRAC_W-1:FILT_BITS_W],
            remote2_frac_in[FILT_BITS_W-1:0] & {FILT_BITS_W{filter_on_in[1]}},
            {REMOTE_RSVD_W{1'b0}}};
    end

    // filter gating happens at conversion time, so a frozen byte keeps
    // the format it was produced with even if the filter is switched
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                live_high[c] <= RESULT_RESET;
                live_low[c] <= RESULT_RESET;
            end
        end else begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                if (conv_valid_in[c]) begin
                    live_high[c] <= conv_high[c];
                    live_low[c] <= conv_low[c];
                end
            end
        end
    end

    // command decode; the pointer itself lives in the bus engine
    always_comb begin
        for (int c = 0; c < NUM_CHAN; c++) begin
            hi_sel[c] = (cmd_in == CMD_HIGH[c]);
            lo_sel[c] = (cmd_in == CMD_LOW[c]);
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_chan
            tvr_low_latch u_latch (
                .sys_clk_in(sys_clk_in),
                .rst_in(rst_in),
                .live_low_in(live_low[g]),
                .capture_in(rd_strobe_in && hi_sel[g]),
                .release_in(rd_strobe_in && lo_sel[g]),
                .locked_out(low_locked_out[g]),
                .low_view_out(low_view[g])
            );
        end
    endgenerate

    // read mux; high bytes are always live, low bytes may be frozen
    always_comb begin
        rd_value = UNMAPPED_VALUE;
        rd_match = 1'b0;
        for (int c = 0; c < NUM_CHAN; c++) begin
            if (hi_sel[c]) begin
                rd_value = live_high[c];
                rd_match = 1'b1;
            end
            if (lo_sel[c]) begin
                rd_value = low_view[c];
                rd_match = 1'b1;
            end
        end
    end

    // data registered on the read pulse, answered one cycle later
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= UNMAPPED_VALUE;
            rd_hit_out <= 1'b0;
            last_cmd <= 8'h00;
        end else if (rd_strobe_in) begin
            rd_data_out <= rd_value;
            rd_hit_out <= rd_match;
            last_cmd <= cmd_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_ack_out <= 1'b0;
        end else begin
            rd_ack_out <= rd_strobe_in;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_high_read(int c);
        rd_strobe_in && cmd_in == CMD_HIGH[c];
    endsequence

    sequence s_low_read(int c);
        rd_strobe_in && cmd_in == CMD_LOW[c];
    endsequence

    AST_LOCK_ON_HIGH: assert property (
        s_high_read(CH_REMOTE1) |=> low_locked_out[CH_REMOTE1])
        else $error("remote 1 low byte not frozen after high read");

    AST_FREEZE_THEN_READ: assert property (
        s_high_read(CH_LOCAL) ##1 (!rd_strobe_in)[*2] ##1 s_low_read(CH_LOCAL)
        |=> rd_ack_out && rd_data_out == $past(live_low[CH_LOCAL], 4))
        else $error("local low read did not return value frozen at high read");

    AST_RELEASE: assert property (
        s_low_read(CH_REMOTE2) |=> !low_locked_out[CH_REMOTE2])
        else $error("remote 2 low byte still frozen after low read");

    AST_HIGH_DATA: assert property (
        s_high_read(CH_REMOTE2) |=> rd_ack_out && rd_hit_out
        && rd_data_out == $past(live_high[CH_REMOTE2]))
        else $error("high byte read returned wrong value");

    AST_LOCAL_LOW_ZERO: assert property (
        rd_ack_out && last_cmd == CMD_LOW[CH_LOCAL]
        |-> rd_data_out[LOCAL_RSVD_W-1:0] == 5'h00)
        else $error("local low byte reserved bits not zero");

    AST_REMOTE_RSVD: assert property (
        rd_ack_out && (last_cmd == CMD_LOW[CH_REMOTE1] || last_cmd == CMD_LOW[CH_REMOTE2])
        |-> rd_data_out[REMOTE_RSVD_W-1:0] == 3'h0)
        else $error("remote low byte bits 2-0 not zero");

    AST_FILTER_OFF: assert property (
        conv_valid_in[CH_REMOTE1] && !filter_on_in[0]
        |=> live_low[CH_REMOTE1][FILT_BIT_HI:FILT_BIT_LO] == 2'b00)
        else $error("filter bits set with remote 1 filter disabled");

    AST_FILTER_ON: assert property (
        conv_valid_in[CH_REMOTE2] && filter_on_in[1]
        |=> live_low[CH_REMOTE2][LOW_FRAC_MSB:REMOTE_FRAC_LSB] == $past(remote2_frac_in))
        else $error("remote 2 fraction not carried with filter enabled");

    AST_LIVE_TRACKS: assert property (
        conv_valid_in[CH_LOCAL] && low_locked_out[CH_LOCAL]
        |=> live_high[CH_LOCAL] == $past(local_high_in))
        else $error("live local result not updated while frozen");

    AST_ACK_PULSE: assert property (
        rd_strobe_in ##1 !rd_strobe_in |-> rd_ack_out ##1 !rd_ack_out)
        else $error("read answer not a single pulse");
endmodule : tvr_readout

//--- shared/tvr_pkg.sv
// constants for the temperature value readout latch
// assumes one internal clock shared by converter, bus engine and this block
package tvr_pkg;
    localparam int NUM_CHAN = 3;
    localparam int CH_LOCAL = 0;
    localparam int CH_REMOTE1 = 1;
    localparam int CH_REMOTE2 = 2;
    // command codes of the result registers, index = channel
    localparam logic [7:0] CMD_HIGH [NUM_CHAN] = '{8'h10, 8'h11, 8'h12};
    localparam logic [7:0] CMD_LOW [NUM_CHAN] = '{8'h20, 8'h21, 8'h22};
    // value answered for a command outside this block
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
    // reset contents of live and frozen bytes
    localparam logic [7:0] RESULT_RESET = 8'h00;
    // low byte field layout
    localparam int LOW_FRAC_MSB = 7;
    localparam int LOCAL_FRAC_LSB = 5;
    localparam int LOCAL_FRAC_W = 3;
    localparam int REMOTE_FRAC_W = 5;
    localparam int REMOTE_FRAC_LSB = 3;
    localparam int FILT_BIT_HI = 4;
    localparam int FILT_BIT_LO = 3;
    localparam int FILT_BITS_W = 2;
    localparam int REMOTE_RSVD_W = 3;
    localparam int LOCAL_RSVD_W = 5;
endpackage : tvr_pkg

//--- tb/tb_tvr_readout.sv
// bench for the readout latch: converter stimulus, host reads, scoreboard
// assumes the host model owns the read port and this module the converter side
module tb_tvr_readout
    import tvr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [2:0] conv_valid_in = 3'h0;
    logic [7:0] hi_drv = 8'h00;
    logic [4:0] frac_drv = 5'h00;
    logic [1:0] filter_on_in = 2'h0;
    logic [7:0] cmd_in;
    logic rd_strobe_in;
    logic [7:0] rd_data_out;
    logic rd_ack_out;
    logic rd_hit_out;
    logic [2:0] low_locked_out;
    logic [7:0] live_hi [3] = '{3{8'h00}};
    logic [7:0] live_lo [3] = '{3{8'h00}};
    logic [7:0] shadow [3] = '{3{8'h00}};
    logic [2:0] lock = 3'h0;
    logic [11:0] exp_q [$];
    logic [11:0] got;
    logic [7:0] cmds [8] = '{8'h10, 8'h11, 8'h12, 8'h20, 8'h21, 8'h22, 8'h03, 8'hFE};
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;

    tvr_host_model host_inst (.sys_clk_in(sys_clk_in), .cmd_out(cmd_in),
        .rd_strobe_out(rd_strobe_in));
    tvr_readout tvr_readout_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .conv_valid_in(conv_valid_in), .local_high_in(hi_drv),
        .local_frac_in(frac_drv[4:2]), .remote1_high_in(hi_drv),
        .remote1_frac_in(frac_drv), .remote2_high_in(hi_drv),
        .remote2_frac_in(frac_drv), .filter_on_in(filter_on_in), .cmd_in(cmd_in),
        .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out), .rd_ack_out(rd_ack_out),
        .rd_hit_out(rd_hit_out), .low_locked_out(low_locked_out));

    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // one cycle: optional read, then optional conversions on the same edge
    task automatic step(input logic [2:0] cv, input logic rd, input logic [7:0] cmd,
                        input logic [7:0] hi, input logic [4:0] fr, input logic [1:0] fon);
        logic [7:0] e;
        logic h;
        int c;
        @(negedge sys_clk_in);
        e = UNMAPPED_VALUE;
        h = 1'b0;
        c = cmd[1:0];
        if (rd && cmd[7:4] == 4'h1 && c < 3) begin
            h = 1'b1;
            e = live_hi[c];
            shadow[c] = live_lo[c];
            lock[c] = 1'b1;
        end else if (rd && cmd[7:4] == 4'h2 && c < 3) begin
            h = 1'b1;
            e = lock[c] ? shadow[c] : live_lo[c];
            lock[c] = 1'b0;
        end
        if (rd) begin
            host_inst.start(cmd);
            exp_q.push_back({h, lock, e});
        end else begin
            host_inst.idle();
        end
        conv_valid_in <= cv;
        hi_drv <= hi;
        frac_drv <= fr;
        filter_on_in <= fon;
        for (c = 0; c < 3; c++) begin
            if (cv[c]) begin
                live_hi[c] = hi;
                live_lo[c] = (c == CH_LOCAL) ? {fr[4:2], 5'h00} :
                    {fr[4:2], fon[c-1] ? fr[1:0] : 2'b00, 3'h0};
            end
        end
    endtask : step

    always @(negedge sys_clk_in) begin
        if (rd_ack_out === 1'b1) begin
            got = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hFFF;
            check("rd_data", rd_data_out, got[7:0]);
            check("rd_hit", {7'h00, rd_hit_out}, {7'h00, got[11]});
            check("locked", {5'h00, low_locked_out}, {5'h00, got[10:8]});
        end
    end

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        int i;
        int c;
        void'($urandom(32'h902E));
        repeat (12) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        check("ack_in_reset", {7'h00, rd_ack_out}, 8'h00);
        rst_in <= 1'b0;
        for (i = 0; i < 8; i++) begin
            step(3'h0, 1'b1, cmds[i], 8'h00, 5'h00, 2'h0);
        end
        // high first, newer conversion, frozen low, then live low
        for (c = 0; c < 3; c++) begin
            step(3'h1 << c, 1'b0, 8'h00, 8'h80, 5'h1F, 2'h3);
            step(3'h0, 1'b1, CMD_HIGH[c], 8'h00, 5'h00, 2'h3);
            step(3'h1 << c, 1'b0, 8'h00, 8'h7F, 5'h0A, 2'h0);
            // two quiet cycles before the low read, as the freeze assertion expects
            step(3'h0, 1'b0, 8'h00, 8'h00, 5'h00, 2'h0);
            step(3'h0, 1'b1, CMD_LOW[c], 8'h00, 5'h00, 2'h0);
            step(3'h0, 1'b1, CMD_LOW[c], 8'h00, 5'h00, 2'h0);
            // second high read recaptures without a low read between
            step(3'h0, 1'b1, CMD_HIGH[c], 8'h00, 5'h00, 2'h3);
            step(3'h1 << c, 1'b0, 8'h00, 8'hC3, 5'h15, 2'h3);
            step(3'h0, 1'b1, CMD_HIGH[c], 8'h00, 5'h00, 2'h3);
            step(3'h7, 1'b1, CMD_LOW[c], 8'h01, 5'h02, 2'h3);
        end
        for (i = 0; i < 400; i++) begin
            step($urandom % 8, $urandom % 2, cmds[$urandom % 8], $urandom, $urandom,
                $urandom);
        end
        step(3'h0, 1'b0, 8'h00, 8'h00, 5'h00, 2'h0);
        repeat (3) @(negedge sys_clk_in);
        check("pending", 8'(exp_q.size()), 8'h00);
        conclude();
    end
endmodule : tb_tvr_readout

//--- tb/tvr_host_model.sv
// partner: bus host reading the temperature result registers
// assumes the bench calls start or idle just after a falling edge
module tvr_host_model (
    input wire logic sys_clk_in,
    output logic [7:0] cmd_out,
    output logic rd_strobe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_out = 8'h00;
        rd_strobe_out = 1'b0;
    end
    // pointer stays where the last command byte left it
    task automatic start(input logic [7:0] cmd);
        cmd_out <= cmd;
        rd_strobe_out <= 1'b1;
    endtask : start
    task automatic idle();
        rd_strobe_out <= 1'b0;
    endtask : idle
endmodule : tvr_host_model
